// ### hw/rdp_ctrl.sv
// Operation
// R1 - 16-bit delay in bits 15:0, 1.024 us units, reset zero; code counts 1.020 us units.
// R2 - completed packet loads the countdown with delay and starts it.
// R3 - another completion before expiry reloads and restarts the countdown.
// R4 - expiry flushes pending write-backs and raises receive timer cause.
// R5 - zero delay signals the receive interrupt immediately per packet.
// R6 - writing flush bit one forces expiry, write-back and timer cause.
// R7 - flush bit self-clears, reads zero; writing zero does nothing.
// R8 - bits 30:16 of delay register read zero.
// R9 - software should issue a second flush for a full write-back.
// R10 - absolute timer interrupt cancels a pending packet timer interrupt.
// R11 - on cancel, countdown reloads but halts until next packet.
// R12 - software should prefer interrupt throttling over packet delay.
// R13 - thresholds in cache lines when granularity 0, descriptors when 1.
// R14 - cache-line thresholds must not exceed 31 descriptors.
// R15 - descriptor granularity writes back all descriptors.
// R16 - prefetch considered only when on-chip count below 6-bit threshold.
// R17 - no fetch unless host holds at least host-threshold descriptors.
// R18 - prefetch starts only with no higher-priority DMA pending.
// R19 - write back only when ready count reaches threshold, unless flushed.
// R20 - granularity flag is bit 24, resets to one.
// R21 - prescaler makes 1.024 us tick decrementing a running countdown; code ticks every 102 cycles of 10 ns, 1.020 us.
// R22 - delay write without flush leaves a running countdown untouched.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "rdp_params.svh"
module rdp_ctrl (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [15:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// dma events
	input  wire logic        i_pkt_done,
	input  wire logic        i_abs_expire,
	input  wire logic        i_wb_done,
	input  wire logic        i_fetch_ack,
	input  wire logic        i_hi_prio_busy,
	// descriptor counts
	input  wire logic [5:0]  i_onchip_valid,
	input  wire logic [5:0]  i_host_valid,
	input  wire logic [5:0]  i_wb_ready,
	input  wire logic [7:0]  i_cache_line_size_field,
	// requests
	output logic             o_wb_req,
	output logic             o_wb_all,
	output logic             o_fetch_req,
	output logic             o_rx_timer_int,
	output logic             o_timer_running
);
	rdp_pkg::rdp_regs_t r_r;
	rdp_pkg::rdp_regs_t r_nxt;
	logic               slverr_r;
	logic               slverr_nxt;
	logic               run_r;

	rdp_tmr_if tif ();

	rdp_delay_timer u_tmr (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.tif     (tif)
	);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        acc;
	logic        wr;
	logic [15:0] off;
	logic        hit_dly;
	logic        hit_fet;
	logic        hit_sts;

	assign acc = i_psel && i_penable && !r_r.pready;
	assign wr = acc && i_pwrite;
	assign off = i_paddr;
	assign hit_dly = (off == `RDP_OFF_DELAY);
	assign hit_fet = (off == `RDP_OFF_FETCH);
	assign hit_sts = (off == `RDP_OFF_STATUS);

	assign tif.delay = r_r.delay;
	assign tif.pkt_done = i_pkt_done;
	assign tif.flush = wr && hit_dly && i_pwdata[`RDP_FLUSH_BIT]; // [R6] [R7]
	assign tif.abs_cancel = i_abs_expire;

	// ----------------------------------------------------------------
	// threshold scaling
	// ----------------------------------------------------------------
	// descriptors per cache line: line size in dwords, four dwords each
	logic [7:0] per_line;
	logic [7:0] pth_d;
	logic [7:0] hth_d;
	logic [7:0] wth_d;

	function automatic logic [7:0] scale(input logic [5:0] th, input logic g,
		input logic [7:0] pl);
		logic [13:0] p;
		p = 14'(th) * 14'(pl);
		if (g) begin
			return {2'b00, th}; // [R13]
		end
		return (p > 14'h00FF) ? 8'hFF : p[7:0]; // [R13]
	endfunction

	always_comb begin
		per_line = {2'b00, i_cache_line_size_field[7:2]};
		if (per_line == 8'h00) begin
			per_line = 8'h01;
		end
	end

	assign pth_d = scale(r_r.pth, r_r.threshold_granularity, per_line);
	assign hth_d = scale(r_r.hth, r_r.threshold_granularity, per_line);
	assign wth_d = scale(r_r.wth, r_r.threshold_granularity, per_line);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_nxt = r_r;
		slverr_nxt = 1'b0;
		r_nxt.pready = acc;
		r_nxt.rx_int = tif.expire; // [R4] [R5] [R6]
		r_nxt.free_threshold_granularity = per_line;
		if (acc) begin
			r_nxt.prdata = 32'h0000_0000;
			if (hit_dly) begin
				// flush bit and 30:16 always read zero
				r_nxt.prdata[`RDP_DELAY_MSB:0] = r_r.delay; // [R7] [R8]
				if (i_pwrite) begin
					r_nxt.delay = i_pwdata[`RDP_DELAY_MSB:0]; // [R1] [R22]
				end
			end else if (hit_fet) begin
				r_nxt.prdata[`RDP_PTH_LSB +: 6] = r_r.pth;
				r_nxt.prdata[`RDP_HTH_LSB +: 6] = r_r.hth;
				r_nxt.prdata[`RDP_WTH_LSB +: 6] = r_r.wth;
				r_nxt.prdata[`RDP_THRESHOLD_GRANULARITY_BIT] = r_r.threshold_granularity;
				if (i_pwrite) begin
					r_nxt.pth = i_pwdata[`RDP_PTH_LSB +: 6]; // [R16]
					r_nxt.hth = i_pwdata[`RDP_HTH_LSB +: 6]; // [R17]
					r_nxt.wth = i_pwdata[`RDP_WTH_LSB +: 6]; // [R19]
					r_nxt.threshold_granularity = i_pwdata[`RDP_THRESHOLD_GRANULARITY_BIT]; // [R20]
				end
			end else if (hit_sts) begin
				r_nxt.prdata = {26'h0, run_r, r_r.flush_pend, r_r.wb_req,
					r_r.fetch_req, r_r.wb_all, r_r.threshold_granularity};
			end else begin
				slverr_nxt = 1'b1;
			end
		end
		// write-back request: threshold or timer flush
		if (tif.expire) begin
			r_nxt.flush_pend = 1'b1; // [R4] [R6]
		end else if (i_wb_done && r_r.wb_req) begin
			r_nxt.flush_pend = 1'b0;
		end
		if (i_wb_done && r_r.wb_req) begin
			r_nxt.wb_req = 1'b0;
		end else if (r_r.flush_pend || ({2'b00, i_wb_ready} >= wth_d
			&& i_wb_ready != 6'h00)) begin
			r_nxt.wb_req = 1'b1; // [R19]
		end
		r_nxt.wb_all = r_r.threshold_granularity; // [R15]
		// prefetch
		if (i_fetch_ack && r_r.fetch_req) begin
			r_nxt.fetch_req = 1'b0;
		end else begin
			r_nxt.fetch_req = ({2'b00, i_onchip_valid} < pth_d) // [R16]
				&& ({2'b00, i_host_valid} >= hth_d) && (i_host_valid != 6'h00) // [R17]
				&& !i_hi_prio_busy && !r_r.wb_req; // [R18]
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r_r <= '{delay: `RDP_DELAY_RST, pth: `RDP_PTH_RST, hth: `RDP_HTH_RST,
				wth: `RDP_WTH_RST, threshold_granularity: `RDP_THRESHOLD_GRANULARITY_RST, prdata: 32'h0000_0000,
				pready: 1'b0, flush_pend: 1'b0, wb_req: 1'b0, wb_all: 1'b1,
				fetch_req: 1'b0, rx_int: 1'b0, free_threshold_granularity: 8'h01};
			slverr_r <= 1'b0;
			run_r <= 1'b0;
		end else begin
			r_r <= r_nxt;
			slverr_r <= slverr_nxt;
			run_r <= tif.running;
		end
	end

	assign o_prdata = r_r.prdata;
	assign o_pready = r_r.pready;
	assign o_pslverr = slverr_r;
	assign o_wb_req = r_r.wb_req;
	assign o_wb_all = r_r.wb_all;
	assign o_fetch_req = r_r.fetch_req;
	assign o_rx_timer_int = r_r.rx_int;
	assign o_timer_running = run_r;
endmodule

// ### hw/rdp_delay_timer.sv
`timescale 1ns/1ps
`include "rdp_params.svh"
module rdp_delay_timer (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// control
	rdp_tmr_if.tmr    tif
);
	localparam logic [6:0] TICK_LAST = 7'(`RDP_TICK_CYC - 1);

	rdp_pkg::rdp_tmr_t s_r;
	rdp_pkg::rdp_tmr_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.expire = 1'b0;
		if (s_r.st == rdp_pkg::RDP_RUN) begin
			if (s_r.pre == TICK_LAST) begin
				s_nxt.pre = 7'h00;
			end else begin
				s_nxt.pre = s_r.pre + 7'h01;
			end
		end
		case (s_r.st)
			rdp_pkg::RDP_RUN: begin
				if (s_r.pre == TICK_LAST) begin
					if (s_r.cnt <= 16'h0001) begin
						s_nxt.expire = 1'b1;
						s_nxt.st = rdp_pkg::RDP_IDLE;
						s_nxt.cnt = 16'h0000;
					end else begin
						s_nxt.cnt = s_r.cnt - 16'h0001; // [R21]
					end
				end
			end
			rdp_pkg::RDP_IDLE,
			rdp_pkg::RDP_HALT: begin
			end
			default: s_nxt.st = rdp_pkg::RDP_IDLE;
		endcase
		if (tif.abs_cancel) begin
			s_nxt.st = rdp_pkg::RDP_HALT; // [R10] [R11]
			s_nxt.cnt = tif.delay;
			s_nxt.expire = 1'b0;
		end
		if (tif.pkt_done) begin
			s_nxt.pre = 7'h00;
			if (tif.delay == 16'h0000) begin
				s_nxt.expire = 1'b1; // [R5]
				s_nxt.st = rdp_pkg::RDP_IDLE;
			end else begin
				s_nxt.cnt = tif.delay; // [R2] [R3]
				s_nxt.st = rdp_pkg::RDP_RUN;
				s_nxt.expire = 1'b0;
			end
		end
		if (tif.flush) begin
			s_nxt.expire = 1'b1; // [R6]
			s_nxt.st = rdp_pkg::RDP_IDLE;
			s_nxt.cnt = 16'h0000;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '{st: rdp_pkg::RDP_IDLE, cnt: 16'h0000, pre: 7'h00, expire: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tif.expire = s_r.expire;
	assign tif.running = (s_r.st == rdp_pkg::RDP_RUN);
endmodule

// ### hw/rdp_params.svh
`ifndef RDP_PARAMS_SVH
`define RDP_PARAMS_SVH

// register byte offsets
`define RDP_OFF_DELAY        16'h2820
`define RDP_OFF_FETCH        16'h2828
`define RDP_OFF_STATUS       16'h2830

// delay register fields
`define RDP_DELAY_MSB        15
`define RDP_FLUSH_BIT        31

// fetch control fields
`define RDP_PTH_LSB          0
`define RDP_HTH_LSB          8
`define RDP_WTH_LSB          16
`define RDP_THRESHOLD_GRANULARITY_BIT         24

// reset values
`define RDP_DELAY_RST        16'h0000
`define RDP_PTH_RST          6'h00
`define RDP_HTH_RST          6'h00
`define RDP_WTH_RST          6'h01
`define RDP_THRESHOLD_GRANULARITY_RST         1'b1

// tick timing
`define RDP_TICK_NS          1024
`define RDP_CLK_NS           10
`define RDP_TICK_CYC         ((`RDP_TICK_NS) / (`RDP_CLK_NS))

`endif

// ### hw/rdp_pkg.sv
package rdp_pkg;

	typedef enum logic [1:0] {
		RDP_IDLE,
		RDP_RUN,
		RDP_HALT
	} rdp_tmr_st_t;

	typedef struct packed {
		logic [15:0] delay;
		logic [5:0]  pth;
		logic [5:0]  hth;
		logic [5:0]  wth;
		logic        threshold_granularity;
		logic [31:0] prdata;
		logic        pready;
		logic        flush_pend;
		logic        wb_req;
		logic        wb_all;
		logic        fetch_req;
		logic        rx_int;
		logic [7:0]  free_threshold_granularity;
	} rdp_regs_t;

	typedef struct packed {
		rdp_tmr_st_t st;
		logic [15:0] cnt;
		logic [6:0]  pre;
		logic        expire;
	} rdp_tmr_t;

endpackage

// ### hw/rdp_tmr_if.sv
`timescale 1ns/1ps
interface rdp_tmr_if;
	logic [15:0] delay;
	logic        pkt_done;
	logic        flush;
	logic        abs_cancel;
	logic        expire;
	logic        running;

	modport ctrl (output delay, output pkt_done, output flush, output abs_cancel,
		input expire, input running);
	modport tmr (input delay, input pkt_done, input flush, input abs_cancel,
		output expire, output running);
endinterface

// ### verification/rdp_ctrl_checker.sv
`timescale 1ns/1ps
module rdp_ctrl_checker (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        i_pkt_done,
	input wire logic        i_abs_expire,
	input wire logic        i_wb_done,
	input wire logic        i_hi_prio_busy,
	input wire logic [5:0]  i_host_valid,
	input wire logic        o_wb_req,
	input wire logic        o_fetch_req,
	input wire logic        o_rx_timer_int,
	input wire logic        o_timer_running
);
	logic zero_r;
	wire  dwr = i_psel && i_penable && !o_pready && i_pwrite && i_paddr == 16'h2820;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			zero_r <= 1'b1;
		else if (dwr)
			zero_r <= i_pwdata[15:0] == 16'h0000;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_flush; dwr && i_pwdata[31]; endsequence
	sequence s_abs_quiet; (i_abs_expire && !i_pkt_done) ##1 !i_pkt_done [*3]; endsequence
	property p_flush_int; s_flush |-> ##[1:2] o_rx_timer_int; endproperty
	a_flush_int: assert property (p_flush_int) else $error("no cause");
	property p_flush_wb; s_flush |-> ##[1:4] o_wb_req; endproperty
	a_flush_wb: assert property (p_flush_wb) else $error("no wb");
	property p_zero; i_pkt_done && zero_r && !i_psel && !i_abs_expire |-> ##2 o_rx_timer_int;
	endproperty
	a_zero: assert property (p_zero) else $error("zero delay");
	property p_wb_hold; o_wb_req && !i_wb_done |=> o_wb_req; endproperty
	a_wb_hold: assert property (p_wb_hold) else $error("wb drop");
	property p_rsv; i_psel && o_pready && !i_pwrite && i_paddr == 16'h2820
		|-> o_prdata[31:16] == 16'h0000; endproperty
	a_rsv: assert property (p_rsv) else $error("rsv bits");
	property p_fetch_idle; o_fetch_req |-> !$past(i_hi_prio_busy) && !$past(o_wb_req); endproperty
	a_fetch_idle: assert property (p_fetch_idle) else $error("fetch busy");
	property p_fetch_host; o_fetch_req |-> $past(i_host_valid) != 6'h00; endproperty
	a_fetch_host: assert property (p_fetch_host) else $error("fetch host");
	property p_abs; s_abs_quiet |=> !o_timer_running; endproperty
	a_abs: assert property (p_abs) else $error("abs run");
endmodule
bind rdp_ctrl rdp_ctrl_checker rdp_ctrl_checker_i (.i_clk, .i_rst_n, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .i_pkt_done, .i_abs_expire,
	.i_wb_done, .i_hi_prio_busy, .i_host_valid, .o_wb_req, .o_fetch_req, .o_rx_timer_int,
	.o_timer_running);

// ### verification/rdp_dma_model.sv
`timescale 1ns/1ps
module rdp_dma_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [3:0] i_lat,
	input  wire logic       i_wb_req,
	input  wire logic       i_fetch_req,
	output logic            o_wb_done,
	output logic            o_fetch_ack
);
	int wcnt;
	// write-back finishes i_lat + 1 cycles after the request
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wcnt <= 0;
			o_wb_done <= 1'b0;
			o_fetch_ack <= 1'b0;
		end else begin
			o_wb_done <= i_wb_req && !o_wb_done && wcnt == i_lat;
			wcnt <= (i_wb_req && !o_wb_done && wcnt < i_lat) ? wcnt + 1 : 0;
			o_fetch_ack <= i_fetch_req && !o_fetch_ack;
		end
	end
endmodule

// ### verification/rx_desc_delay_and_prefetch_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module rx_desc_delay_and_prefetch_ctrl_bench;
	logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_pkt_done, i_abs_expire;
	logic        i_wb_done, i_fetch_ack, i_hi_prio_busy, o_pready, o_pslverr, err;
	logic        o_wb_req, o_wb_all, o_fetch_req, o_rx_timer_int, o_timer_running, exp_f;
	logic [15:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic [5:0]  i_onchip_valid, i_host_valid, i_wb_ready;
	logic [7:0]  i_cache_line_size_field;
	logic [3:0]  lat;
	int          error_cnt, n_checks, cyc, ints, int_at, seed, m_dly, m_ctl, t0, k, i, sc;
	rdp_ctrl rdp_ctrl_i (.*);
	rdp_dma_model rdp_dma_model_i (.i_clk, .i_rst_n, .i_lat(lat), .i_wb_req(o_wb_req),
		.i_fetch_req(o_fetch_req), .o_wb_done(i_wb_done), .o_fetch_ack(i_fetch_ack));
	initial begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_rx_timer_int === 1'b1) begin
			ints++;
			int_at = cyc;
		end
		if (cyc > 20000) begin
			error_cnt++;
			final_report;
		end
	end
	task final_report;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk) {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
		@(posedge i_clk) i_penable <= 1'b1;
		do @(posedge i_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task rdchk(input logic [15:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask
	task pulse(input logic abs);
		@(posedge i_clk) {i_abs_expire, i_pkt_done} <= {abs, !abs};
		@(posedge i_clk) {i_abs_expire, i_pkt_done} <= 2'b00;
		t0 = cyc;
	endtask
	initial begin
		seed = 61975;
		{i_psel, i_penable, i_pwrite, i_pkt_done, i_abs_expire, i_hi_prio_busy} = 6'h00;
		{i_paddr, i_pwdata, i_onchip_valid, i_host_valid, i_wb_ready} = 66'h0;
		i_cache_line_size_field = 8'h10;
		lat = 4'h2;
		i_rst_n = 1'b0;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rdchk(16'h2820, 32'h0, "delay rst");
		rdchk(16'h2828, 32'h01010000, "ctl rst");
		for (i = 0; i < 4; i++) begin
			m_ctl = $random(seed);
			apb(1'b1, 16'h2828, m_ctl);
			rdchk(16'h2828, m_ctl & 32'h013F3F3F, "ctl");
			m_dly = $random(seed) & 32'h7FFFFFFF;
			apb(1'b1, 16'h2820, m_dly);
			rdchk(16'h2820, m_dly & 32'hFFFF, "delay");
		end
		rdchk(16'h2824, 32'h0, "unmapped");
		`CHK("slverr", 1'b1, err)
		apb(1'b1, 16'h2820, 32'h0);
		k = ints;
		pulse(1'b0);
		repeat (4) @(posedge i_clk);
		`CHK("zero", k + 1, ints)
		m_dly = 3;
		apb(1'b1, 16'h2820, m_dly);
		pulse(1'b0);
		repeat (150) @(posedge i_clk);
		pulse(1'b0);
		apb(1'b1, 16'h2820, 32'h5);
		repeat (m_dly * 102 - 30) @(posedge i_clk);
		`CHK("early", k + 1, ints)
		`CHK("running", 1'b1, o_timer_running)
		repeat (40) @(posedge i_clk);
		`CHK("expiry", k + 2, ints)
		`CHK("cycles", 1'b1, int_at - t0 >= 302 && int_at - t0 <= 312)
		pulse(1'b0);
		repeat (100) @(posedge i_clk);
		pulse(1'b1);
		repeat (600) @(posedge i_clk);
		`CHK("cancel", k + 2, ints)
		`CHK("halted", 1'b0, o_timer_running)
		pulse(1'b0);
		repeat (20) @(posedge i_clk);
		apb(1'b1, 16'h2820, 32'h80000005);
		repeat (2) @(posedge i_clk);
		`CHK("flush", k + 3, ints)
		`CHK("wb req", 1'b1, o_wb_req)
		apb(1'b1, 16'h2820, 32'h80000005);
		rdchk(16'h2820, 32'h5, "self clear");
		apb(1'b1, 16'h2820, 32'h5);
		repeat (600) @(posedge i_clk);
		`CHK("one flush", k + 4, ints)
		`CHK("wb done", 1'b0, o_wb_req)
		apb(1'b1, 16'h2820, 32'h0);
		for (i = 0; i < 24; i++) begin
			m_dly = $random(seed);
			m_ctl = (m_dly[6] << 24) | (m_dly[5:3] << 8) | m_dly[2:0];
			i_onchip_valid <= {1'b0, m_dly[12:8]};
			i_host_valid <= {1'b0, m_dly[17:13]};
			i_hi_prio_busy <= m_dly[18] & m_dly[19];
			apb(1'b1, 16'h2828, m_ctl);
			repeat (2) @(posedge i_clk);
			sc = m_dly[6] ? 1 : 4;
			exp_f = m_dly[12:8] < m_dly[2:0] * sc && m_dly[17:13] >= m_dly[5:3] * sc;
			exp_f = exp_f && m_dly[17:13] != 0 && !(m_dly[18] & m_dly[19]);
			rd[0] = o_fetch_req;
			`CHK("wb all", m_dly[6], o_wb_all)
			@(posedge i_clk);
			// the prefetch handshake drops the request one cycle in three
			`CHK("fetch", exp_f, rd[0] | o_fetch_req)
		end
		final_report;
	end
endmodule
